// *** rtl/perr_defines.vh ***
// register offsets, field positions and reset values for the ring/irq bank
`ifndef PERR_DEFINES_VH
`define PERR_DEFINES_VH
// byte addresses are four times the printed register index
`define PERR_IDX_CAP 6'h12
`define PERR_IDX_ENT 6'h13
`define PERR_IDX_IEN 6'h1C
`define PERR_IDX_IPND 6'h1D
`define PERR_IDX_RING 6'h1E
`define PERR_CAP_TEMP 15
`define PERR_CAP_QUAD 14
`define PERR_CAP_CRYPT 12
`define PERR_CAP_DUAL 10
`define PERR_CAP_KEY256 8
`define PERR_IRQ_BITS 11
`define PERR_IRQ_SWO 4
`define PERR_RING_MSTART 15
`define PERR_RING_ADV 14
`define PERR_RING_LPADV 13
`define PERR_RING_FORCE 12
`define PERR_RING_ROLE_HI 5
`define PERR_RING_ROLE_LO 4
`define PERR_RING_START 0
`define PERR_ROLE_SLAVE 2'h0
`define PERR_ROLE_S2M 2'h2
`define PERR_ROLE_MASTER 2'h3
`define PERR_ROLE_M2S 2'h1
`define PERR_SWO_NS 1000
`define PERR_CLK_NS 10
`define PERR_SWO_CYC ((`PERR_SWO_NS + `PERR_CLK_NS - 1) / `PERR_CLK_NS)
`define PERR_LFSR_SEED 16'hACE1
`endif

// *** rtl/perr_entropy.v ***
// free-running lfsr that supplies the random word
`timescale 1ns/100ps
`default_nettype none
`include "perr_defines.vh"
module perr_entropy (
   input wire clk,
   input wire rst_b,
   input wire advance,
   output wire [15:0] value
);
   reg [15:0] lfsr_q;
   wire fb;
   // taps 16,14,13,11 give a maximal length sequence
   assign fb = lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10];
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lfsr_q <= `PERR_LFSR_SEED;
      end else begin
         // steps every cycle; a read also mixes in an extra step
         if (advance) begin
            lfsr_q <= {lfsr_q[13:0], fb, ~lfsr_q[15]};
         end else begin
            lfsr_q <= {lfsr_q[14:0], fb};
         end
      end
   end
   assign value = lfsr_q;
endmodule
`default_nettype wire

// *** rtl/perr_regs.v ***
// apb register bank: identity, entropy, extended irq and ring control
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "perr_defines.vh"
module perr_regs #(
   parameter IND_TEMP = 1'b0,
   parameter QUAD_DEV = 1'b0,
   parameter CRYPT_CAP = 1'b1,
   parameter DUAL_MEDIA = 1'b1,
   parameter KEY256_CAP = 1'b1,
   // arbitrary neutral variant code
   parameter [7:0] VARIANT_BCD = 8'h42,
   parameter SWO_CYCLES = `PERR_SWO_CYC
) (
   input wire clk,
   input wire rst_b,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [10:0] irq_event,
   input wire link_partner_ring_adv,
   input wire link_up,
   input wire aneg_master,
   output wire ring_resiliency_adv,
   output wire ring_resiliency_force,
   output wire ring_master_start_en,
   output wire irq
);
   localparam S_IDLE = 2'h0;
   localparam S_SWO = 2'h1;
   localparam [31:0] SWO_M1 = SWO_CYCLES - 1;
   localparam [15:0] SWO_LAST = SWO_M1[15:0];

   reg lpadv_s1_q, lpadv_s2_q;
   reg [1:0] lu_s1_q, lu_s2_q;
   reg ms_s1_q, ms_s2_q;
   reg [10:0] ev_s1_q, ev_s2_q, ev_prev_q;
   reg [4:0] ien_q;
   reg [10:0] ipnd_q;
   reg mstart_q, adv_q, force_q;
   reg [1:0] role_q;
   reg [1:0] st_q;
   reg [15:0] cnt_q;
   reg linked_q;
   reg [31:0] rdata_d;

   wire access;
   wire wr;
   wire rd;
   wire [5:0] idx;
   wire hit;
   wire [15:0] cap_word;
   wire [15:0] ent_word;
   wire [10:0] ev_rise;
   wire swo_done;
   wire swo_start;
   wire lu_rise;

   function is_reg;
      input [5:0] i;
      begin
         is_reg = (i == `PERR_IDX_CAP) || (i == `PERR_IDX_ENT) ||
                  (i == `PERR_IDX_IEN) || (i == `PERR_IDX_IPND) ||
                  (i == `PERR_IDX_RING);
      end
   endfunction

   function [1:0] stable_role;
      input m;
      begin
         stable_role = m ? `PERR_ROLE_MASTER : `PERR_ROLE_SLAVE;
      end
   endfunction

   assign access = psel & penable;
   assign wr = access & pwrite;
   assign rd = access & ~pwrite;
   assign idx = paddr[7:2];
   assign hit = is_reg(idx) && (paddr[31:8] == 24'h000000) &&
                (paddr[1:0] == 2'h0);
   assign pready = 1'b1;
   assign pslverr = access & ~hit;

   // two-stage synchronisers on everything arriving from other logic; link_up passes three stages before its edge detect
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lpadv_s1_q <= 1'b0;
         lpadv_s2_q <= 1'b0;
         lu_s1_q <= 2'h0;
         lu_s2_q <= 2'h0;
         ms_s1_q <= 1'b0;
         ms_s2_q <= 1'b0;
         ev_s1_q <= 11'h000;
         ev_s2_q <= 11'h000;
         ev_prev_q <= 11'h000;
      end else begin
         lpadv_s1_q <= link_partner_ring_adv;
         lpadv_s2_q <= lpadv_s1_q;
         lu_s1_q <= {lu_s1_q[0], link_up};
         lu_s2_q <= {lu_s2_q[0], lu_s1_q[1]};
         ms_s1_q <= aneg_master;
         ms_s2_q <= ms_s1_q;
         ev_s1_q <= irq_event;
         ev_s2_q <= ev_s1_q;
         ev_prev_q <= ev_s2_q;
      end
   end

   assign ev_rise = ev_s2_q & ~ev_prev_q;
   assign lu_rise = lu_s2_q[0] & ~lu_s2_q[1];

   perr_entropy u_ent (
      .clk(clk),
      .rst_b(rst_b),
      .advance(rd && hit && (idx == `PERR_IDX_ENT)),
      .value(ent_word)
   );

   assign cap_word = {IND_TEMP[0],
                      QUAD_DEV[0], 1'b0, CRYPT_CAP[0], 1'b0,
                      DUAL_MEDIA[0], 1'b0, KEY256_CAP[0],
                      VARIANT_BCD};

   // control and mask registers
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ien_q <= 5'h00;
         mstart_q <= 1'b0;
         adv_q <= 1'b0;
         force_q <= 1'b0;
      end else if (wr && hit && pstrb[0] && (idx == `PERR_IDX_IEN)) begin
         ien_q <= pwdata[4:0];
      end else if (wr && hit && (idx == `PERR_IDX_RING) && pstrb[1]) begin
         mstart_q <= pwdata[`PERR_RING_MSTART];
         adv_q <= pwdata[`PERR_RING_ADV];
         force_q <= pwdata[`PERR_RING_FORCE];
      end
   end

   // pending bits: a new event wins over the clearing read
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ipnd_q <= 11'h000;
      end else begin
         if (rd && hit && (idx == `PERR_IDX_IPND)) begin
            // clear only what the setup cycle captured, so an event
            // landing between setup and access is not lost
            ipnd_q <= (ipnd_q & ~prdata[10:0]) | ev_rise |
                      {6'h00, swo_done, 4'h0};
         end else begin
            ipnd_q <= ipnd_q | ev_rise | {6'h00, swo_done, 4'h0};
         end
      end
   end

   assign swo_start = wr && hit && (idx == `PERR_IDX_RING) && pstrb[0] &&
                      pwdata[`PERR_RING_START] && (st_q == S_IDLE);
   assign swo_done = (st_q == S_SWO) && (cnt_q == SWO_LAST);

   // switchover sequencer; a request while busy is dropped
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= S_IDLE;
         cnt_q <= 16'h0000;
         role_q <= `PERR_ROLE_SLAVE;
         linked_q <= 1'b0;
      end else begin
         if (lu_rise && !linked_q && (st_q == S_IDLE)) begin
            role_q <= stable_role(ms_s2_q);
            linked_q <= 1'b1;
         end
         case (st_q)
            S_IDLE: begin
               cnt_q <= 16'h0000;
               if (swo_start) begin
                  st_q <= S_SWO;
                  role_q <= (role_q == `PERR_ROLE_MASTER) ?
                            `PERR_ROLE_M2S : `PERR_ROLE_S2M;
               end
            end
            S_SWO: begin
               cnt_q <= cnt_q + 16'h0001;
               if (swo_done) begin
                  st_q <= S_IDLE;
                  role_q <= (role_q == `PERR_ROLE_S2M) ?
                            `PERR_ROLE_MASTER : `PERR_ROLE_SLAVE;
               end
            end
            default: begin
               st_q <= S_IDLE;
               cnt_q <= 16'h0000;
            end
         endcase
      end
   end

   // read mux; start bit always reads zero since it self-clears
   always @* begin
      rdata_d = 32'h00000000;
      case (idx)
         `PERR_IDX_CAP: rdata_d[15:0] = cap_word;
         `PERR_IDX_ENT: rdata_d[15:0] = ent_word;
         `PERR_IDX_IEN: rdata_d[4:0] = ien_q;
         `PERR_IDX_IPND: rdata_d[10:0] = ipnd_q;
         `PERR_IDX_RING: begin
            rdata_d[`PERR_RING_MSTART] = mstart_q;
            rdata_d[`PERR_RING_ADV] = adv_q;
            rdata_d[`PERR_RING_LPADV] = lpadv_s2_q;
            rdata_d[`PERR_RING_FORCE] = force_q;
            rdata_d[`PERR_RING_ROLE_HI:`PERR_RING_ROLE_LO] = role_q;
         end
         default: rdata_d = 32'h00000000;
      endcase
      if (!hit) begin
         rdata_d = 32'h00000000;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rdata_d;
      end
   end

   assign ring_resiliency_adv = adv_q;
   assign ring_resiliency_force = force_q;
   assign ring_master_start_en = mstart_q;
   assign irq = |(ipnd_q[4:0] & ien_q) | (|ipnd_q[10:5]);
endmodule
`default_nettype wire

// *** dv/perr_regs_checker.sv ***
// port-level assertions for the ring/irq register bank
`timescale 1ns/100ps
`default_nettype none
module perr_regs_checker #(
   parameter IND_TEMP = 1'b0,
   parameter [7:0] VARIANT_BCD = 8'h42
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic [10:0] irq_event,
   input wire logic ring_resiliency_adv,
   input wire logic ring_resiliency_force,
   input wire logic ring_master_start_en,
   input wire logic irq
);
   wire rd = psel & penable & ~pwrite;
   wire ring_wr = psel & penable & pwrite & (paddr == 32'h78) & pstrb[1];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   cap_temp_a: assert property (rd && paddr == 32'h48 |->
      prdata[15] == IND_TEMP) else $error("grade bit wrong");
   cap_var_a: assert property (rd && paddr == 32'h48 |->
      prdata[7:0] == VARIANT_BCD) else $error("variant byte wrong");
   pend_rsvd_a: assert property (rd && paddr == 32'h74 |->
      prdata[31:11] == 0) else $error("status high bits set");
   start_rd0_a: assert property (rd && paddr == 32'h78 |->
      prdata[11:6] == 0 && prdata[3:0] == 0) else $error("ring zeros");
   adv_out_a: assert property (ring_wr |=>
      ring_resiliency_adv == $past(pwdata[14])) else $error("adv out");
   force_out_a: assert property (ring_wr |=>
      ring_resiliency_force == $past(pwdata[12])) else $error("force");
   mstart_out_a: assert property (ring_wr |=>
      ring_master_start_en == $past(pwdata[15])) else $error("mstart");
   irq_rise_a: assert property ($rose(irq_event[10]) |->
      ##[1:4] irq) else $error("irq missing after event");
endmodule
bind perr_regs perr_regs_checker #(.IND_TEMP(IND_TEMP),
   .VARIANT_BCD(VARIANT_BCD)) perr_regs_checker_inst (.clk(clk),
   .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .irq_event(irq_event), .ring_resiliency_adv(ring_resiliency_adv),
   .ring_resiliency_force(ring_resiliency_force),
   .ring_master_start_en(ring_master_start_en), .irq(irq));
`default_nettype wire

// *** dv/perr_regs_tb.sv ***
// self-checking bench for the ring/irq register bank
`timescale 1ns/100ps
`default_nettype none
module perr_regs_tb;
   localparam SWO = 8;
   logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, e;
   logic lp_adv = 0, link_up = 0, aneg_m = 0;
   logic [31:0] paddr = 0, pwdata = 0, r, r2;
   logic [31:0] ra [3] = '{32'h70, 32'h74, 32'h78};
   logic [3:0] pstrb = 0;
   logic [10:0] irq_event = 0;
   wire [31:0] prdata;
   wire pready, pslverr, irq, rr_adv, rr_force, rr_mst;
   int err_total = 0, check_count = 0, cyc = 0;
   perr_regs #(.VARIANT_BCD(8'h37), .SWO_CYCLES(SWO)) perr_regs_inst (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_event(irq_event), .link_partner_ring_adv(lp_adv),
      .link_up(link_up), .aneg_master(aneg_m),
      .ring_resiliency_adv(rr_adv), .ring_resiliency_force(rr_force),
      .ring_master_start_en(rr_mst), .irq(irq));
   initial forever #5 clk = ~clk;
   task stop_test;
      if (err_total == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         stop_test;
      end
   end
   task chk(input logic [31:0] s, x);
      check_count++;
      if (s !== x) begin
         err_total++;
         $display("BAD %0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   // one idle edge first, so back-to-back calls never double-drive psel
   task apb(input logic w, input logic [31:0] a, d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= {4{w}};
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1;
      foreach (ra[i]) begin
         apb(0, ra[i], 0);
         chk(r, 0);
      end
      apb(1, 32'h48, 32'hFFFF);
      apb(0, 32'h48, 0);
      chk(r, 32'h1537);
      apb(0, 32'h4C, 0);
      r2 = r;
      apb(0, 32'h4C, 0);
      chk(r === r2 || r[31:16] !== 16'h0, 0);
      apb(1, 32'h70, 32'hFFFFFFFF);
      apb(0, 32'h70, 0);
      chk(r, 32'h1F);
      apb(1, 32'h70, 32'h15);
      for (int i = 0; i < 11; i++) begin
         irq_event <= 11'h1 << i;
         repeat (6) @(posedge clk);
         chk(irq, i > 4 || i % 2 == 0);
         apb(0, 32'h74, 0);
         chk(r, 32'h1 << i);
         apb(0, 32'h74, 0);
         chk(r | irq, 0);
         irq_event <= 0;
         repeat (2) @(posedge clk);
      end
      lp_adv <= 1;
      apb(1, 32'h78, 32'hD000);
      apb(0, 32'h78, 0);
      chk(r, 32'hF000);
      chk({rr_mst, rr_adv, rr_force}, 3'h7);
      aneg_m <= 1;
      link_up <= 1;
      repeat (6) @(posedge clk);
      apb(0, 32'h78, 0);
      chk(r, 32'hF030);
      for (int k = 0; k < 2; k++) begin
         apb(1, 32'h78, 32'hD001);
         // a second start while busy must change nothing
         apb(1, 32'h78, 32'hD001);
         apb(0, 32'h78, 0);
         chk(r, k ? 32'hF020 : 32'hF010);
         repeat (SWO + 4) @(posedge clk);
         apb(0, 32'h78, 0);
         chk(r, k ? 32'hF030 : 32'hF000);
         apb(0, 32'h74, 0);
         chk(r, 32'h10);
      end
      apb(0, 32'h7C, 0);
      chk({r[30:0], e}, 1);
      stop_test;
   end
endmodule
`default_nettype wire
